// ### src/opda_pkg.sv
// shared constants and types for the operator panel display/alter block
package opda_pkg;
   localparam int IR_W = 30;
   localparam int OP_W = 8;
   localparam int ADR_W = 16;
   localparam int CH_W = 6;
   localparam int OP_LSB = 22;
   localparam int ADR_LSB = 6;
   localparam int CH_LSB = 0;
   localparam int OPREF_W = 5;
   localparam int OPREF_LSB = 3;
   localparam int NSEL = 9;
   localparam int NTRACE = 5;
   localparam int LAMP_W = 31;
   localparam int LAMP_PAR = 30;
   localparam int TR_OP = 0;
   localparam logic [7:0] WB_CTRL = 8'h00;
   localparam logic [7:0] WB_STAT = 8'h04;
   localparam logic [7:0] WB_LAMP = 8'h08;
   localparam int CTRL_ARM = 0;
   localparam int CTRL_CLR = 1;
   localparam int ST_STOP = 0;
   localparam int ST_TRACE = 1;
   localparam int ST_REFUSE = 2;
   localparam int ST_BUSY = 3;

   typedef enum logic [3:0] {
      SEL_Q1 = 4'h0, SEL_Q2 = 4'h1, SEL_CC = 4'h2, SEL_INST = 4'h3,
      SEL_OPCH = 4'h4, SEL_M = 4'h5, SEL_C = 4'h6, SEL_MEM = 4'h7,
      SEL_SEQ = 4'h8, SEL_NONE = 4'hF
   } opda_sel_e;

   typedef enum logic [1:0] {
      MS_IDLE = 2'b00, MS_READ = 2'b01, MS_WRITE = 2'b10
   } opda_mst_e;

   typedef struct packed {
      logic [NSEL-1:0] sel;
      logic disp;
      logic alter;
      logic [IR_W-1:0] sw;
      logic tmode;
      logic [NTRACE-1:0] ttype;
   } opda_pins_s;

   typedef struct packed {
      logic req;
      logic we;
      logic [ADR_W-1:0] addr;
      logic [CH_W-1:0] wdata;
   } opda_mem_s;
endpackage : opda_pkg

// ### src/opda_panel.sv
// operator panel display and alter logic with wishbone status port
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module opda_panel #(
   parameter logic [7:0] JUMP_LOOP_OP = 8'h01,
   parameter logic [7:0] INDEX_OP = 8'h02
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire opda_pkg::opda_pins_s pins_i,
   input wire logic proc_stopped_i,
   input wire logic staticize_i,
   input wire logic [opda_pkg::IR_W-1:0] ir_i,
   input wire logic [opda_pkg::ADR_W-1:0] cc_i,
   input wire logic [opda_pkg::IR_W-1:0] q1_i,
   input wire logic [opda_pkg::IR_W-1:0] q2_i,
   input wire logic [opda_pkg::CH_W-1:0] mem_rdata_i,
   input wire logic mem_rpar_i,
   input wire logic mem_ack_i,
   output logic [opda_pkg::LAMP_W-1:0] lamps_o,
   output logic ir_wr_o,
   output logic [opda_pkg::IR_W-1:0] ir_wdata_o,
   output logic reg_wr_o,
   output logic [3:0] reg_tgt_o,
   output logic [opda_pkg::IR_W-1:0] reg_wdata_o,
   output opda_pkg::opda_mem_s mem_o,
   output logic trace_halt_o,
   output logic trace_stop_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   import opda_pkg::*;

   typedef struct packed {
      opda_pins_s s1;
      opda_pins_s s2;
      opda_pins_s s3;
      opda_pins_s pin;
      logic disp_prev;
      logic alter_prev;
      logic [LAMP_W-1:0] lamps;
      logic ir_wr;
      logic [IR_W-1:0] ir_wdata;
      logic reg_wr;
      logic [3:0] reg_tgt;
      logic [IR_W-1:0] reg_wdata;
      opda_mem_s mem;
      opda_mst_e mst;
      logic [CH_W-1:0] mem_data;
      logic mem_par;
      logic [ADR_W-1:0] seq_addr;
      logic trace_halt;
      logic trace_stop;
      logic refused;
      logic arm;
      logic wb_ack;
      logic [31:0] wb_dat;
   } opda_st_s;

   opda_st_s r_q;
   opda_st_s r_d;

   // lowest set button wins; the panel interlock keeps only one down
   function automatic opda_sel_e sel_code(input logic [NSEL-1:0] b);
      opda_sel_e c;
      c = SEL_NONE;
      for (int i = NSEL - 1; i >= 0; i--) begin
         if (b[i]) begin
            c = opda_sel_e'(i[3:0]);
         end
      end
      return c;
   endfunction : sel_code

   function automatic logic no_inject(input logic [OP_W-1:0] op);
      return (op == JUMP_LOOP_OP) || (op == INDEX_OP);
   endfunction : no_inject

   // the four selections whose alter lands in the instruction register
   function automatic logic ir_sel(input opda_sel_e s);
      return (s == SEL_INST) || (s == SEL_OPCH) || (s == SEL_M)
         || (s == SEL_C);
   endfunction : ir_sel

   always_comb begin
      logic disp_p;
      logic alter_p;
      logic stopped;
      logic wb_req;
      logic [IR_W-1:0] nir;
      logic [ADR_W-1:0] acc_addr;
      opda_sel_e sel;
      disp_p = 1'b0;
      alter_p = 1'b0;
      stopped = proc_stopped_i;
      wb_req = 1'b0;
      nir = ir_i;
      acc_addr = '0;
      sel = SEL_NONE;
      r_d = r_q;
      r_d.ir_wr = 1'b0;
      r_d.reg_wr = 1'b0;
      r_d.trace_halt = 1'b0;
      r_d.wb_ack = 1'b0;

      // three stage pin capture; a level counts once stages two and three agree
      r_d.s1 = pins_i;
      r_d.s2 = r_q.s1;
      r_d.s3 = r_q.s2;
      if (r_q.s2 == r_q.s3) begin
         r_d.pin = r_q.s3;
      end

      // one press, one command
      r_d.disp_prev = r_q.pin.disp;
      r_d.alter_prev = r_q.pin.alter;
      disp_p = r_q.pin.disp & ~r_q.disp_prev & stopped;
      alter_p = r_q.pin.alter & ~r_q.alter_prev & stopped;
      sel = sel_code(r_q.pin.sel);

      if (alter_p) begin
         case (sel)
            SEL_INST: begin
               nir = r_q.pin.sw;
            end
            SEL_OPCH: begin
               nir[OP_LSB +: OP_W] = r_q.pin.sw[OP_LSB +: OP_W];
            end
            SEL_M: begin
               nir[ADR_LSB +: ADR_W] = r_q.pin.sw[ADR_LSB +: ADR_W];
            end
            SEL_C: begin
               nir[CH_LSB +: CH_W] = r_q.pin.sw[CH_LSB +: CH_W];
            end
            default: begin
               nir = ir_i;
            end
         endcase
         case (sel)
            SEL_INST, SEL_OPCH, SEL_M, SEL_C: begin
               // refused instead of letting a loop run on a short counter
               if (no_inject(nir[OP_LSB +: OP_W])) begin
                  r_d.refused = 1'b1;
               end else begin
                  r_d.ir_wr = 1'b1;
                  r_d.ir_wdata = nir;
               end
            end
            SEL_Q1, SEL_Q2, SEL_CC: begin
               r_d.reg_wr = 1'b1;
               r_d.reg_tgt = sel;
               r_d.reg_wdata = r_q.pin.sw;
            end
            default: begin
               r_d.reg_wr = 1'b0;
            end
         endcase
      end

      // storage access; commands arriving while busy are dropped
      acc_addr = (sel == SEL_SEQ) ? r_q.seq_addr
                                  : r_q.pin.sw[ADR_LSB +: ADR_W];
      case (r_q.mst)
         MS_IDLE: begin
            if ((sel == SEL_MEM) || (sel == SEL_SEQ)) begin
               if (alter_p) begin
                  r_d.mst = MS_WRITE;
                  r_d.mem.req = 1'b1;
                  r_d.mem.we = 1'b1;
                  r_d.mem.addr = acc_addr;
                  r_d.mem.wdata = r_q.pin.sw[CH_LSB +: CH_W];
               end else if (disp_p) begin
                  r_d.mst = MS_READ;
                  r_d.mem.req = 1'b1;
                  r_d.mem.we = 1'b0;
                  r_d.mem.addr = acc_addr;
               end
            end
         end
         MS_READ: begin
            if (mem_ack_i) begin
               r_d.mst = MS_IDLE;
               r_d.mem.req = 1'b0;
               r_d.mem.we = 1'b0;
               r_d.seq_addr = r_q.mem.addr + 16'h0001;
               r_d.mem_data = mem_rdata_i;
               r_d.mem_par = mem_rpar_i;
            end
         end
         MS_WRITE: begin
            if (mem_ack_i) begin
               r_d.mst = MS_IDLE;
               r_d.mem.req = 1'b0;
               r_d.mem.we = 1'b0;
               r_d.seq_addr = r_q.mem.addr + 16'h0001;
               // written char shown with even parity, as storage keeps it
               r_d.mem_data = r_q.mem.wdata;
               r_d.mem_par = ^r_q.mem.wdata;
            end
         end
         default: begin
            r_d.mst = MS_IDLE;
            r_d.mem.req = 1'b0;
         end
      endcase

      // lamps recomputed every cycle from the live selection
      r_d.lamps = '0;
      case (sel)
         SEL_Q1: begin
            r_d.lamps[IR_W-1:0] = q1_i;
         end
         SEL_Q2: begin
            r_d.lamps[IR_W-1:0] = q2_i;
         end
         SEL_CC: begin
            r_d.lamps[IR_W-1:0] = ir_i;
            r_d.lamps[ADR_LSB +: ADR_W] = cc_i;
         end
         SEL_MEM, SEL_SEQ: begin
            r_d.lamps[IR_W-1:0] = ir_i;
            r_d.lamps[ADR_LSB +: ADR_W] = r_q.seq_addr;
            r_d.lamps[CH_LSB +: CH_W] = r_q.mem_data;
            r_d.lamps[LAMP_PAR] = r_q.mem_par;
         end
         default: begin
            r_d.lamps[IR_W-1:0] = ir_i;
         end
      endcase

      // op trace: only type op compares; other types belong elsewhere
      if (r_q.pin.tmode && r_q.arm && r_q.pin.ttype[TR_OP] && staticize_i
          && (ir_i[OP_LSB+OPREF_LSB +: OPREF_W]
              == r_q.pin.sw[OP_LSB+OPREF_LSB +: OPREF_W])) begin
         r_d.trace_halt = 1'b1;
      end

      // wishbone slave, one wait state, ack dropped the cycle after
      wb_req = wb_cyc_i & wb_stb_i & ~r_q.wb_ack;
      if (wb_req) begin
         r_d.wb_ack = 1'b1;
         r_d.wb_dat = '0;
         case (wb_adr_i)
            WB_CTRL: begin
               r_d.wb_dat[CTRL_ARM] = r_q.arm;
               if (wb_we_i && wb_sel_i[0]) begin
                  r_d.arm = wb_dat_i[CTRL_ARM];
                  if (wb_dat_i[CTRL_CLR]) begin
                     r_d.trace_stop = 1'b0;
                     r_d.refused = 1'b0;
                  end
               end
            end
            WB_STAT: begin
               r_d.wb_dat[ST_STOP] = stopped;
               r_d.wb_dat[ST_TRACE] = r_q.trace_stop;
               r_d.wb_dat[ST_REFUSE] = r_q.refused;
               r_d.wb_dat[ST_BUSY] = (r_q.mst != MS_IDLE);
            end
            WB_LAMP: begin
               r_d.wb_dat[LAMP_W-1:0] = r_q.lamps;
            end
            default: begin
               r_d.wb_dat = '0;
            end
         endcase
      end
      // a new event beats a clear in the same cycle
      if (r_q.trace_halt) begin
         r_d.trace_stop = 1'b1;
      end
      if (alter_p && r_d.ir_wr == 1'b0 && ir_sel(sel)) begin
         r_d.refused = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r_q <= '0;
         r_q.mst <= MS_IDLE;
      end else if (clk_en) begin
         r_q <= r_d;
      end
   end

   assign lamps_o = r_q.lamps;
   assign ir_wr_o = r_q.ir_wr;
   assign ir_wdata_o = r_q.ir_wdata;
   assign reg_wr_o = r_q.reg_wr;
   assign reg_tgt_o = r_q.reg_tgt;
   assign reg_wdata_o = r_q.reg_wdata;
   assign mem_o = r_q.mem;
   assign trace_halt_o = r_q.trace_halt;
   assign trace_stop_o = r_q.trace_stop;
   assign wb_dat_o = r_q.wb_dat;
   assign wb_ack_o = r_q.wb_ack;
endmodule : opda_panel

// ### verification/opda_panel_properties.sv
// port assertions for the operator panel block
`timescale 1ns/100ps
module opda_panel_props #(
   parameter logic [7:0] JUMP_LOOP_OP = 8'h01,
   parameter logic [7:0] INDEX_OP = 8'h02
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic ir_wr_o,
   input wire logic [opda_pkg::IR_W-1:0] ir_wdata_o,
   input wire opda_pkg::opda_mem_s mem_o,
   input wire logic mem_ack_i,
   input wire logic proc_stopped_i,
   input wire logic staticize_i,
   input wire logic trace_halt_o,
   input wire logic trace_stop_o
);
   import opda_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      && clk_en |=> wb_ack_o) else $error("bus ack missing");
   ack_pulse_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
      else $error("bus ack too long");
   ir_pulse_a: assert property (ir_wr_o && clk_en |=> !ir_wr_o)
      else $error("ir write not a pulse");
   ir_stopped_a: assert property (ir_wr_o |-> $past(proc_stopped_i))
      else $error("ir written while running");
   no_jump_a: assert property (ir_wr_o |-> ir_wdata_o[29:22] !=
      JUMP_LOOP_OP && ir_wdata_o[29:22] != INDEX_OP)
      else $error("forbidden op injected");
   req_hold_a: assert property (mem_o.req && !mem_ack_i |=> mem_o.req
      && $stable(mem_o.addr)) else $error("storage request dropped");
   req_drop_a: assert property (mem_o.req && mem_ack_i |=> !mem_o.req)
      else $error("storage request kept after ack");
   halt_cause_a: assert property (trace_halt_o |-> $past(staticize_i))
      else $error("halt without staticize");
   halt_lamp_a: assert property (trace_halt_o |=> trace_stop_o)
      else $error("trace stop lamp dark");
   cover property (ir_wr_o);
   cover property (mem_o.req && mem_o.we && mem_ack_i);
   cover property (trace_halt_o);
endmodule : opda_panel_props

bind opda_panel opda_panel_props #(.JUMP_LOOP_OP(JUMP_LOOP_OP),
   .INDEX_OP(INDEX_OP)) u_props (.clk, .sys_rst, .clk_en, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .ir_wr_o, .ir_wdata_o, .mem_o, .mem_ack_i,
   .proc_stopped_i, .staticize_i, .trace_halt_o, .trace_stop_o);

// ### verification/opda_store_model.sv
// behavioural core storage behind the panel
`timescale 1ns/100ps
module opda_store_model (
   input wire logic clk,
   input wire opda_pkg::opda_mem_s mem_i,
   input wire logic [3:0] delay,
   output logic [5:0] rdata,
   output logic rpar,
   output logic ack
);
   import opda_pkg::*;
   logic [CH_W:0] store [0:65535];
   logic [3:0] cnt_q = 4'h0;
   logic hold_q = 1'b0;
   initial {ack, rpar, rdata} = '0;
   always @(posedge clk) begin
      // idle lines toggle so stale data never looks valid
      {rpar, rdata} <= ~{rpar, rdata};
      ack <= 1'b0;
      if (!mem_i.req) begin
         hold_q <= 1'b0;
         cnt_q <= 4'h0;
      end else if (!hold_q && !ack) begin
         if (cnt_q != delay) cnt_q <= cnt_q + 4'h1;
         else begin
            ack <= 1'b1;
            hold_q <= 1'b1;
            if (mem_i.we) store[mem_i.addr] <= {^mem_i.wdata, mem_i.wdata};
            else {rpar, rdata} <= store[mem_i.addr];
         end
      end
   end
endmodule : opda_store_model

// ### verification/test_operator_panel_display_alter.sv
// self-checking bench for the operator panel block
`timescale 1ns/100ps
module test_operator_panel_display_alter;
   import opda_pkg::*;
   logic clk, sys_rst, clk_en, proc_stopped_i, staticize_i, mem_rpar_i;
   logic mem_ack_i, ir_wr_o, trace_halt_o, trace_stop_o, wb_ack_o;
   logic wb_cyc_i, wb_stb_i, wb_we_i;
   opda_pins_s pins_i;
   opda_mem_s mem_o;
   logic [IR_W-1:0] ir_i, q1_i, q2_i, ir_wdata_o, ir_last;
   logic reg_wr_o;
   logic [3:0] reg_tgt_o;
   logic [IR_W-1:0] reg_wdata_o, reg_last;
   int reg_n = 0;
   logic [ADR_W-1:0] cc_i;
   logic [CH_W-1:0] mem_rdata_i;
   logic [LAMP_W-1:0] lamps_o;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [3:0] delay;
   int failures = 0, comparisons = 0, cycles = 0, ir_n = 0, halt_n = 0;

   opda_panel u_dut (.clk, .sys_rst, .clk_en, .pins_i, .proc_stopped_i,
      .staticize_i, .ir_i, .cc_i, .q1_i, .q2_i, .mem_rdata_i, .mem_rpar_i,
      .mem_ack_i, .lamps_o, .ir_wr_o, .ir_wdata_o, .reg_wr_o,
      .reg_tgt_o, .reg_wdata_o, .mem_o, .trace_halt_o, .trace_stop_o,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF),
      .wb_dat_i, .wb_dat_o, .wb_ack_o);
   opda_store_model u_mem (.clk, .mem_i(mem_o), .delay,
      .rdata(mem_rdata_i), .rpar(mem_rpar_i), .ack(mem_ack_i));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (ir_wr_o === 1'b1) ir_n++;
      if (ir_wr_o === 1'b1) ir_last = ir_wdata_o;
      if (trace_halt_o === 1'b1) halt_n++;
      if (reg_wr_o === 1'b1) reg_n++;
      if (reg_wr_o === 1'b1) reg_last = reg_wdata_o;
      // about twenty-five times the length of the full sequence
      if (cycles == 20000) begin
         failures++;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wb(input logic we, input logic [7:0] a, input int d);
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'b11, we, a};
      wb_dat_i <= d;
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask : wb

   // generous waits: buttons pass a three-stage sync first
   task automatic press(input int s, input logic alt);
      pins_i.sel <= 9'(1 << s);
      repeat (8) @(posedge clk);
      {pins_i.alter, pins_i.disp} <= {alt, !alt};
      repeat (8) @(posedge clk);
      {pins_i.alter, pins_i.disp} <= 2'b00;
      repeat (40) @(posedge clk);
   endtask : press

   task automatic alter_fields();
      logic [IR_W-1:0] m [4] = '{30'h3FFFFFFF, 30'h3FC00000,
         30'h003FFFC0, 30'h0000003F};
      int n;
      pins_i.sw <= 30'h0AAAAAAA;
      for (int i = 0; i < 4; i++) begin
         n = ir_n;
         press(3 + i, 1'b1);
         check(ir_n - n, 1);
         check(ir_last, ir_i & ~m[i] | pins_i.sw & m[i]);
      end
      proc_stopped_i <= 1'b0;
      press(3, 1'b1);
      check(ir_n - n, 1);
      proc_stopped_i <= 1'b1;
      pins_i.sw[29:22] <= 8'h01;
      press(3, 1'b1);
      check(ir_n - n, 1);
      wb(1'b0, WB_STAT, 0);
      check(q[ST_REFUSE], 1);
      wb(1'b1, WB_CTRL, 2);
   endtask : alter_fields

   task automatic views();
      {cc_i, q1_i, q2_i} <= {16'hBEEF, 30'h12345678, 30'h2468ACE0};
      for (int i = 0; i < 3; i++) begin
         pins_i.sel <= 9'(1 << i);
         repeat (8) @(posedge clk);
         check(lamps_o[29:0], i == 0 ? q1_i : i == 1 ? q2_i :
            {ir_i[29:22], cc_i, ir_i[5:0]});
      end
      cc_i <= 16'h0F0F;
      repeat (2) @(posedge clk);
      check(lamps_o[21:6], cc_i);
      // register alter goes out on the register write port
      pins_i.sw <= 30'h01234567;
      press(1, 1'b1);
      check(reg_n, 1);
      check(reg_tgt_o, 1);
      check(reg_last, 30'h01234567);
   endtask : views

   task automatic storage();
      pins_i.sw <= {8'h00, 16'h1234, 6'h2D};
      press(7, 1'b1);
      check(u_mem.store[16'h1234], {^6'h2D, 6'h2D});
      check(lamps_o[21:6], 16'h1235);
      press(7, 1'b0);
      check({lamps_o[30], lamps_o[21:0]}, {^6'h2D, 22'h048D6D});
      delay <= 4'h0;
      pins_i.sw[5:0] <= 6'h17;
      press(8, 1'b1);
      check(u_mem.store[16'h1235], {^6'h17, 6'h17});
      check(lamps_o[21:6], 16'h1236);
      press(7, 1'b0);
      press(8, 1'b0);
      check(lamps_o[21:0], {16'h1236, 6'h17});
   endtask : storage

   task automatic trace_op();
      int n;
      wb(1'b1, WB_CTRL, 1);
      {proc_stopped_i, pins_i.tmode, pins_i.sw[29:25]} <= {2'b01, 5'h0B};
      for (int i = 0; i < 6; i++) begin
         pins_i.ttype <= 5'(1 << (i % 5));
         ir_i[29:25] <= i == 5 ? 5'h0C : 5'h0B;
         n = halt_n;
         repeat (8) @(posedge clk);
         staticize_i <= 1'b1;
         @(posedge clk);
         staticize_i <= 1'b0;
         repeat (4) @(posedge clk);
         check(halt_n - n, i == 0);
      end
      wb(1'b0, WB_STAT, 0);
      check(q[ST_TRACE], 1);
      wb(1'b1, WB_CTRL, 2);
      proc_stopped_i <= 1'b1;
   endtask : trace_op

   task automatic complete_run();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   initial begin
      {sys_rst, clk_en, proc_stopped_i, staticize_i} = 4'b1110;
      {pins_i, ir_i, q1_i, q2_i, cc_i} = '0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      delay = 4'h5;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      ir_i <= 30'h15555555;
      wb(1'b0, 8'h0C, 0);
      check(q, 32'h0);
      alter_fields();
      views();
      storage();
      trace_op();
      wb(1'b0, WB_LAMP, 0);
      check(q[30:0], lamps_o);
      complete_run();
   end
endmodule : test_operator_panel_display_alter
